// File: core/iglc_line_ctrl.sv
// Design decision made here: register access over APB.
`timescale 1ns/1ns
module iglc_line_ctrl (
  input  wire logic                         clk_sys,     // 125 MHz clock
  input  wire logic                         arst_n,      // async reset, low
  input  wire logic                         psel,        // apb select
  input  wire logic                         penable,     // apb access phase
  input  wire logic                         pwrite,      // apb direction
  input  wire logic [iglc_pkg::IGLC_ADDR_W-1:0] paddr,   // apb byte address
  input  wire logic [31:0]                  pwdata,      // apb write data
  input  wire logic [3:0]                   pstrb,       // apb byte strobes
  output logic                              pready,      // apb ready
  output logic [31:0]                       prdata,      // apb read data
  output logic                              pslverr,     // apb error
  input  wire logic                         lineAIn,     // internal line a level
  input  wire logic                         lineBIn,     // internal line b level
  output logic                              lineAOut,    // line a drive value
  output logic                              lineAOe,     // line a driven
  output logic                              lineBOut,    // line b drive value
  output logic                              lineBOe,     // line b driven
  output logic                              irq          // level interrupt
);
  import iglc_pkg::*;

  // ==========================================================================
  // elaboration checks
  // the decode below assumes a word map that fits the address bus
  if (IGLC_ADDR_W < 9) begin : g_addr_w_chk
    $error("address bus too narrow for the register map");
  end
  // every register is one aligned word
  if (IGLC_LINE_CTRL_OFS[1:0] != 2'h0 || IGLC_IRQ_STAT_OFS[1:0] != 2'h0
      || IGLC_IRQ_MASK_OFS[1:0] != 2'h0) begin : g_align_chk
    $error("register offsets must be word aligned");
  end
  // the writable mask must cover exactly the named fields
  if (IGLC_CTRL_WMASK != ((32'h1 << IGLC_B_IRQ_EN_BIT) | (32'h1 << IGLC_B_INV_BIT) | (32'h1 << IGLC_B_OE_BIT)
      | (32'h1 << IGLC_B_DATA_BIT) | (32'h1 << IGLC_A_IRQ_EN_BIT) | (32'h1 << IGLC_A_INV_BIT)
      | (32'h1 << IGLC_A_OE_BIT) | (32'h1 << IGLC_A_DATA_BIT))) begin : g_wmask_chk
    $error("writable mask disagrees with the field positions");
  end
  // status and mask hold one bit per line
  if (IGLC_EVT_A_BIT == IGLC_EVT_B_BIT || IGLC_EVT_A_BIT > 1 || IGLC_EVT_B_BIT > 1) begin : g_evt_chk
    $error("event bits must be distinct and fit two bits");
  end

  // ==========================================================================
  // state
  typedef struct packed {
    logic [31:0] ctrl;
    logic [1:0]  evtStat;
    logic [1:0]  evtMask;
    logic [1:0]  lineSeen;
    logic        ready;
    logic [31:0] rdata;
    logic        slverr;
    logic        aOut;
    logic        aOe;
    logic        bOut;
    logic        bOe;
    logic        irq;
  } iglc_state_s;

  iglc_state_s st_r;
  iglc_state_s st_nxt;

  function automatic logic [31:0] iglc_strb_merge(input logic [31:0] old, input logic [31:0] wd,
                                                  input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : iglc_strb_merge

  logic [1:0]  lineSense;
  logic [1:0]  lineChg;
  logic [31:0] ctrlView;
  logic        wrEn;
  logic        rdEn;
  logic [31:0] wMerged;

  // ==========================================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    // sense after inversion; lines are on-chip only, never a pad
    lineSense[IGLC_EVT_A_BIT] = lineAIn ^ st_r.ctrl[IGLC_A_INV_BIT];
    lineSense[IGLC_EVT_B_BIT] = lineBIn ^ st_r.ctrl[IGLC_B_INV_BIT];
    st_nxt.lineSeen = lineSense;
    lineChg[IGLC_EVT_A_BIT] = (lineSense[IGLC_EVT_A_BIT] ^ st_r.lineSeen[IGLC_EVT_A_BIT])
                              & st_r.ctrl[IGLC_A_IRQ_EN_BIT];
    lineChg[IGLC_EVT_B_BIT] = (lineSense[IGLC_EVT_B_BIT] ^ st_r.lineSeen[IGLC_EVT_B_BIT])
                              & st_r.ctrl[IGLC_B_IRQ_EN_BIT];
    ctrlView = st_r.ctrl;
    ctrlView[IGLC_A_DATA_BIT] = lineSense[IGLC_EVT_A_BIT];
    ctrlView[IGLC_B_DATA_BIT] = lineSense[IGLC_EVT_B_BIT];
    wrEn = psel && penable && pwrite && !st_r.ready;
    rdEn = psel && penable && !pwrite && !st_r.ready;
    wMerged = 32'h00000000;
    st_nxt.ready = psel && penable && !st_r.ready;
    st_nxt.slverr = 1'b0;
    st_nxt.rdata = 32'h00000000;
    if (rdEn) begin
      unique case (paddr)
        IGLC_LINE_CTRL_OFS: st_nxt.rdata = ctrlView;
        IGLC_IRQ_STAT_OFS:  st_nxt.rdata = {30'h0, st_r.evtStat};
        IGLC_IRQ_MASK_OFS:  st_nxt.rdata = {30'h0, st_r.evtMask};
        default:            st_nxt.slverr = 1'b1;
      endcase
    end
    if (wrEn) begin
      unique case (paddr)
        IGLC_LINE_CTRL_OFS: begin
          // data bits store drive value; reserved bits stay zero
          wMerged = iglc_strb_merge(st_r.ctrl, pwdata, pstrb);
          st_nxt.ctrl = wMerged & IGLC_CTRL_WMASK;
        end
        IGLC_IRQ_STAT_OFS: begin
          if (pstrb[0]) begin
            st_nxt.evtStat = st_r.evtStat & ~pwdata[1:0];
          end
        end
        IGLC_IRQ_MASK_OFS: begin
          if (pstrb[0]) begin
            st_nxt.evtMask = pwdata[1:0];
          end
        end
        default: st_nxt.slverr = 1'b1;
      endcase
    end
    // set wins over a simultaneous clear
    st_nxt.evtStat = st_nxt.evtStat | lineChg;
    st_nxt.irq = |(st_nxt.evtStat & st_nxt.evtMask);
    st_nxt.aOe = st_nxt.ctrl[IGLC_A_OE_BIT];
    st_nxt.bOe = st_nxt.ctrl[IGLC_B_OE_BIT];
    st_nxt.aOut = st_nxt.ctrl[IGLC_A_DATA_BIT] ^ st_nxt.ctrl[IGLC_A_INV_BIT];
    st_nxt.bOut = st_nxt.ctrl[IGLC_B_DATA_BIT] ^ st_nxt.ctrl[IGLC_B_INV_BIT];
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pready   = st_r.ready;
  assign prdata   = st_r.rdata;
  assign pslverr  = st_r.slverr;
  assign lineAOut = st_r.aOut;
  assign lineAOe  = st_r.aOe;
  assign lineBOut = st_r.bOut;
  assign lineBOe  = st_r.bOe;
  assign irq      = st_r.irq;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // request qualifiers as the design takes them
  logic accTake;
  logic ctrlWr;
  logic ctrlRd;
  logic statWr;
  logic maskWr;
  logic unmapped;
  assign accTake  = psel && penable && !st_r.ready;
  assign ctrlWr   = accTake && pwrite && paddr == IGLC_LINE_CTRL_OFS;
  assign ctrlRd   = accTake && !pwrite && paddr == IGLC_LINE_CTRL_OFS;
  assign statWr   = accTake && pwrite && paddr == IGLC_IRQ_STAT_OFS;
  assign maskWr   = accTake && pwrite && paddr == IGLC_IRQ_MASK_OFS;
  assign unmapped = paddr != IGLC_LINE_CTRL_OFS && paddr != IGLC_IRQ_STAT_OFS
                    && paddr != IGLC_IRQ_MASK_OFS;

  // ==========================================================================
  // bus timing: one wait state, answer stands one cycle
  ready_wait_a: assert property (
    accTake |=> pready)
    else $error("no answer after one wait state");

  ready_pulse_a: assert property (
    pready |=> !pready)
    else $error("ready held");

  slverr_map_a: assert property (
    accTake && unmapped |=> pready && pslverr)
    else $error("unmapped access not refused");

  rdata_idle_a: assert property (
    !pready |-> prdata == 32'h00000000 && !pslverr)
    else $error("read data outside answer");

  // ==========================================================================
  // reset: lines released, no inversion, events off
  rst_clear_a: assert property (
    $rose(arst_n) |-> st_r.ctrl == IGLC_CTRL_RST && !lineAOe && !lineBOe && !irq)
    else $error("reset state wrong");

  // ==========================================================================
  // change events and interrupt
  // a change is judged on the sensed level, so an invert write is left out
  b_change_evt_a: assert property (
    st_r.ctrl[IGLC_B_IRQ_EN_BIT] && $changed(lineBIn) && !$past(ctrlWr) |=> st_r.evtStat[IGLC_EVT_B_BIT])
    else $error("line b change lost");

  a_change_evt_a: assert property (
    st_r.ctrl[IGLC_A_IRQ_EN_BIT] && $changed(lineAIn) && !$past(ctrlWr) |=> st_r.evtStat[IGLC_EVT_A_BIT])
    else $error("line a change lost");

  b_quiet_a: assert property (
    !st_r.ctrl[IGLC_B_IRQ_EN_BIT] |=> !st_r.evtStat[IGLC_EVT_B_BIT] || $past(st_r.evtStat[IGLC_EVT_B_BIT]))
    else $error("line b event while disabled");

  a_quiet_a: assert property (
    !st_r.ctrl[IGLC_A_IRQ_EN_BIT] |=> !st_r.evtStat[IGLC_EVT_A_BIT] || $past(st_r.evtStat[IGLC_EVT_A_BIT]))
    else $error("line a event while disabled");

  no_evt_off_a: assert property (
    !st_r.ctrl[IGLC_B_IRQ_EN_BIT] && !st_r.ctrl[IGLC_A_IRQ_EN_BIT] && !(psel && penable && pwrite)
    |=> (st_r.evtStat & ~$past(st_r.evtStat)) == 2'h0)
    else $error("event set while disabled");

  b_clear_a: assert property (
    statWr && pstrb[0] && pwdata[IGLC_EVT_B_BIT] && !st_r.ctrl[IGLC_B_IRQ_EN_BIT] |=> !st_r.evtStat[IGLC_EVT_B_BIT])
    else $error("line b flag not cleared");

  a_clear_a: assert property (
    statWr && pstrb[0] && pwdata[IGLC_EVT_A_BIT] && !st_r.ctrl[IGLC_A_IRQ_EN_BIT] |=> !st_r.evtStat[IGLC_EVT_A_BIT])
    else $error("line a flag not cleared");

  mask_write_a: assert property (
    maskWr && pstrb[0] |=> st_r.evtMask == $past(pwdata[1:0]))
    else $error("mask write lost");

  mask_hold_a: assert property (
    !maskWr |=> $stable(st_r.evtMask))
    else $error("mask changed without write");

  irq_mask_a: assert property (
    irq == |(st_r.evtStat & st_r.evtMask))
    else $error("irq disagrees with mask");

  b_event_irq_a: assert property (
    st_r.ctrl[IGLC_B_IRQ_EN_BIT] && $changed(lineBIn) && !$past(ctrlWr) && st_r.evtMask[IGLC_EVT_B_BIT]
    && !maskWr |=> irq)
    else $error("line b event gave no irq");

  a_event_irq_a: assert property (
    st_r.ctrl[IGLC_A_IRQ_EN_BIT] && $changed(lineAIn) && !$past(ctrlWr) && st_r.evtMask[IGLC_EVT_A_BIT]
    && !maskWr |=> irq)
    else $error("line a event gave no irq");

  // ==========================================================================
  // drive paths
  b_drive_a: assert property (
    lineBOe == st_r.ctrl[IGLC_B_OE_BIT] && lineBOut == (st_r.ctrl[IGLC_B_DATA_BIT] ^ st_r.ctrl[IGLC_B_INV_BIT]))
    else $error("line b drive wrong");

  a_drive_a: assert property (
    lineAOe == st_r.ctrl[IGLC_A_OE_BIT] && lineAOut == (st_r.ctrl[IGLC_A_DATA_BIT] ^ st_r.ctrl[IGLC_A_INV_BIT]))
    else $error("line a drive wrong");

  b_release_a: assert property (
    !st_r.ctrl[IGLC_B_OE_BIT] |-> !lineBOe)
    else $error("line b driven while released");

  a_release_a: assert property (
    !st_r.ctrl[IGLC_A_OE_BIT] |-> !lineAOe)
    else $error("line a driven while released");

  b_store_a: assert property (
    ctrlWr && pstrb[3] |=> st_r.ctrl[IGLC_B_DATA_BIT] == $past(pwdata[IGLC_B_DATA_BIT]))
    else $error("line b drive value not stored");

  a_store_a: assert property (
    ctrlWr && pstrb[2] |=> st_r.ctrl[IGLC_A_DATA_BIT] == $past(pwdata[IGLC_A_DATA_BIT]))
    else $error("line a drive value not stored");

  ctrl_hold_a: assert property (
    !ctrlWr |=> $stable(st_r.ctrl))
    else $error("control changed without write");

  // ==========================================================================
  // read view of the control register
  // data bits show the sensed input, never the stored drive value
  rd_live_a: assert property (
    ctrlRd |=> pready && prdata[IGLC_B_DATA_BIT] == ($past(lineBIn) ^ $past(st_r.ctrl[IGLC_B_INV_BIT]))
    && prdata[IGLC_A_DATA_BIT] == ($past(lineAIn) ^ $past(st_r.ctrl[IGLC_A_INV_BIT])))
    else $error("data read not live");

  rsvd_zero_a: assert property (
    (st_r.ctrl & ~IGLC_CTRL_WMASK) == 32'h00000000)
    else $error("reserved bit set");

  rsvd_read_a: assert property (
    ctrlRd |=> (prdata & ~IGLC_CTRL_WMASK) == 32'h00000000)
    else $error("reserved bit read nonzero");

  // ==========================================================================
  // main scenarios
  rd_ctrl_c: cover property (psel && penable && !pwrite && paddr == IGLC_LINE_CTRL_OFS ##1 pready);
  b_evt_c:   cover property (st_r.evtStat[IGLC_EVT_B_BIT] && irq);
  a_drv_c:   cover property (lineAOe && lineAOut);
  clr_c:     cover property (st_r.evtStat != 2'h0 ##1 st_r.evtStat == 2'h0);
  err_c:     cover property (pready && pslverr);
endmodule : iglc_line_ctrl

// File: core/iglc_pkg.sv
package iglc_pkg;
  // ==========================================================================
  // register map
  localparam logic [11:0] IGLC_LINE_CTRL_OFS = 12'h0fc;
  localparam logic [11:0] IGLC_IRQ_STAT_OFS  = 12'h100;
  localparam logic [11:0] IGLC_IRQ_MASK_OFS  = 12'h104;
  localparam logic [31:0] IGLC_CTRL_RST      = 32'h00000000;
  localparam int          IGLC_ADDR_W        = 12;
  // ==========================================================================
  // line-control field positions
  localparam int IGLC_B_IRQ_EN_BIT = 31;
  localparam int IGLC_B_INV_BIT    = 29;
  localparam int IGLC_B_OE_BIT     = 28;
  localparam int IGLC_B_DATA_BIT   = 24;
  localparam int IGLC_A_IRQ_EN_BIT = 23;
  localparam int IGLC_A_INV_BIT    = 21;
  localparam int IGLC_A_OE_BIT     = 20;
  localparam int IGLC_A_DATA_BIT   = 16;
  // writable bits of the line-control register, all others reserved
  localparam logic [31:0] IGLC_CTRL_WMASK = 32'hb1b10000;
  // status and mask layout: bit 0 line a change, bit 1 line b change
  localparam int IGLC_EVT_A_BIT = 0;
  localparam int IGLC_EVT_B_BIT = 1;
  localparam logic [1:0] IGLC_EVT_RST = 2'h0;
endpackage : iglc_pkg

// File: core/iglc_unused_guard.sv
`timescale 1ns/1ns

// File: bench/iglc_line_partner.sv
`timescale 1ns/1ns
// ====
// internal logic on both lines: yields while the device drives
module iglc_line_partner (
  input  wire logic lineAOut, // device drive a
  input  wire logic lineAOe,  // device enable a
  input  wire logic lineBOut, // device drive b
  input  wire logic lineBOe,  // device enable b
  input  wire logic drvA,     // own level a
  input  wire logic drvB,     // own level b
  output logic      lineAIn,  // resolved a
  output logic      lineBIn   // resolved b
);
  assign lineAIn = lineAOe ? lineAOut : drvA;
  assign lineBIn = lineBOe ? lineBOut : drvB;
endmodule : iglc_line_partner

// File: bench/tb.sv
`timescale 1ns/1ns
// ====
// bench
module tb;
  import iglc_pkg::*;
  logic        clk_sys = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, drvA = 0, drvB = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, w, sh;
  logic        pready, pslverr, lineAIn, lineBIn, lineAOut, lineAOe, lineBOut, lineBOe, irq;
  logic [32:0] q[$];
  int          n_mismatch = 0, n_checks = 0, cyc = 0;
  always #4 clk_sys = ~clk_sys;
  iglc_line_ctrl iglc_line_ctrl_inst (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .lineAIn(lineAIn), .lineBIn(lineBIn), .lineAOut(lineAOut), .lineAOe(lineAOe),
    .lineBOut(lineBOut), .lineBOe(lineBOe), .irq(irq));
  iglc_line_partner iglc_line_partner_inst (.lineAOut(lineAOut), .lineAOe(lineAOe), .lineBOut(lineBOut),
    .lineBOe(lineBOe), .drvA(drvA), .drvB(drvB), .lineAIn(lineAIn), .lineBIn(lineBIn));
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // read results are noted here and compared by the monitor
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) q.push_back(e);
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  // data bits read the live wire after inversion
  function automatic logic [31:0] expCtrl(input logic [31:0] s);
    expCtrl = s;
    expCtrl[16] = (s[20] ? s[16] ^ s[21] : drvA) ^ s[21];
    expCtrl[24] = (s[28] ? s[24] ^ s[29] : drvB) ^ s[29];
  endfunction : expCtrl
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (pready === 1'b1 && psel && penable && !pwrite) chk({pslverr, prdata}, q.pop_front());
    if (cyc == 4000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(12528));
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    chk({31'h0, lineAOe, lineBOe}, 33'h0);
    apb(0, IGLC_LINE_CTRL_OFS, 0, {1'b0, IGLC_CTRL_RST});
    apb(0, 12'h200, 0, 33'h100000000);
    repeat (12) begin
      {drvA, drvB} <= 2'($urandom);
      w = $urandom;
      sh = w & IGLC_CTRL_WMASK;
      apb(1, IGLC_LINE_CTRL_OFS, w, 0);
      chk({31'h0, lineAOe, lineAOe & lineAOut}, {31'h0, sh[20], sh[20] & (sh[16] ^ sh[21])});
      chk({31'h0, lineBOe, lineBOe & lineBOut}, {31'h0, sh[28], sh[28] & (sh[24] ^ sh[29])});
      apb(0, IGLC_LINE_CTRL_OFS, 0, {1'b0, expCtrl(sh)});
    end
    apb(1, IGLC_LINE_CTRL_OFS, 32'h80800000, 0);
    apb(1, IGLC_IRQ_STAT_OFS, 32'h3, 0);
    apb(1, IGLC_IRQ_MASK_OFS, 32'h1, 0);
    drvA <= ~drvA;
    repeat (4) @(posedge clk_sys);
    chk({32'h0, irq}, 33'h1);
    apb(0, IGLC_IRQ_STAT_OFS, 0, 33'h1);
    drvB <= ~drvB;
    repeat (4) @(posedge clk_sys);
    apb(0, IGLC_IRQ_STAT_OFS, 0, 33'h3);
    apb(1, IGLC_IRQ_STAT_OFS, 32'h1, 0);
    chk({32'h0, irq}, 33'h0);
    apb(0, IGLC_IRQ_STAT_OFS, 0, 33'h2);
    apb(1, IGLC_LINE_CTRL_OFS, 0, 0);
    apb(1, IGLC_IRQ_STAT_OFS, 32'h3, 0);
    drvA <= ~drvA;
    repeat (4) @(posedge clk_sys);
    apb(0, IGLC_IRQ_STAT_OFS, 0, 33'h0);
    print_verdict();
  end
endmodule : tb
